// ===== design/rhb_header_builder.sv
// Record header builder: gathers record metadata and emits the 40-byte header
// How it works
// - One status byte: range, fill, loss
// - One programmable user identifier byte per header
// - One channel byte naming the source channel
// - Serial number as unsigned 32-bit number
// - 32-bit record counter, one step per record
// - Record counter wraps to zero after maximum
// - Sample period, signed 32-bit, 25 ps units
// - Trigger time, unsigned 64-bit, 25 ps units
// - Start offset, signed 64-bit, 25 ps units
// - Record length as 32-bit sample count
// - 16-bit general purpose word per header
// - 16-bit count of timestamp resets
// - Bit 7 set on any range fault
// - Bits 6..4 give fill level in eighths
// - Fill field keeps highest level seen
// - Bits 3..1 flag loss, zero otherwise; bit 0 always zero
// - Bit 1 marks lost record beginning
// - Bit 2 marks lost middle segments
// - Bit 3 marks lost record end
// - Format byte: 0 is 16-bit, 1 is 32-bit
// - Header is always exactly forty bytes
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "rhb_map.svh"

module rhb_header_builder #(
  parameter int HDR_BYTES = `RHB_HDR_BYTES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        rec_start,
  input  wire logic [7:0]  rec_chan,
  input  wire logic [63:0] trigger_time_field,
  input  wire logic [63:0] rec_start_offset,
  input  wire logic        rec_end,
  input  wire logic [31:0] rec_len,
  input  wire logic        range_fault,
  input  wire logic [2:0]  fifo_fill,
  input  wire logic        lost_begin,
  input  wire logic        lost_mid,
  input  wire logic        lost_end,
  input  wire logic        ts_reset_evt,
  output logic             cap_ready,
  output logic             hdr_valid,
  input  wire logic        hdr_ready,
  output logic [7:0]       hdr_data,
  output logic             hdr_first,
  output logic             hdr_last
);
  import rhb_pkg::*;

  initial begin
    if (HDR_BYTES != `RHB_HDR_BYTES) begin
      $error("header size must be forty bytes");
    end
  end

  rhb_regs_t r;
  rhb_regs_t next_r;
  logic [7:0] status;
  logic [7:0] fmt_byte;
  logic       set_user_tag_command;
  logic       accept;

  // ----------------------------------------
  // Combinational outputs
  // ----------------------------------------
  assign cap_ready = (r.st != RHB_SEND);
  assign hdr_valid = (r.st == RHB_SEND);
  assign hdr_data  = r.sh[7:0];
  assign hdr_first = hdr_valid && (r.idx == 6'd0);
  assign hdr_last  = hdr_valid && (r.idx == `RHB_HDR_LAST);
  assign reg_rdata = r.rdata;
  assign accept    = hdr_valid && hdr_ready;
  assign set_user_tag_command = reg_wr && (reg_addr == `RHB_REG_USER_TAG);

  // ----------------------------------------
  // Status and format bytes
  // ----------------------------------------
  always_comb begin
    status = 8'h00;
    status[`RHB_ST_OVR] = r.ovr | range_fault;
    status[`RHB_ST_FILL_HI:`RHB_ST_FILL_LO] =
      (fifo_fill > r.fill) ? fifo_fill : r.fill;
    status[`RHB_ST_LOST_REC] = 1'b0;
    status[`RHB_ST_LOST_BEG] = r.lost[0] | lost_begin;
    status[`RHB_ST_LOST_MID] = r.lost[1] | lost_mid;
    status[`RHB_ST_LOST_END] = r.lost[2] | lost_end;
    fmt_byte = r.fmt ? `RHB_FMT_S32 : `RHB_FMT_S16;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    // Register writes
    if (set_user_tag_command) begin
      next_r.uid = reg_wdata[7:0];
    end
    if (reg_wr && reg_addr == `RHB_REG_FORMAT) begin
      next_r.fmt = reg_wdata[0];
    end
    if (reg_wr && reg_addr == `RHB_REG_SERIAL) begin
      next_r.serial = reg_wdata;
    end
    if (reg_wr && reg_addr == `RHB_REG_PERIOD) begin
      next_r.period = reg_wdata;
    end
    if (reg_wr && reg_addr == `RHB_REG_GP) begin
      next_r.gp = reg_wdata[15:0];
    end
    // Register reads
    next_r.rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RHB_REG_USER_TAG: next_r.rdata = {24'h000000, r.uid};
        `RHB_REG_FORMAT:   next_r.rdata = {31'h00000000, r.fmt};
        `RHB_REG_SERIAL:   next_r.rdata = r.serial;
        `RHB_REG_PERIOD:   next_r.rdata = r.period;
        `RHB_REG_GP:       next_r.rdata = {16'h0000, r.gp};
        `RHB_REG_REC_CNT:  next_r.rdata = r.recno;
        `RHB_REG_TS_RST:   next_r.rdata = {16'h0000, r.tsr};
        `RHB_REG_STATUS:   next_r.rdata = {22'h000000, r.st, status};
        default:           next_r.rdata = 32'h00000000;
      endcase
    end
    // Timestamp reset counter
    if (ts_reset_evt) begin
      next_r.tsr = r.tsr + 16'h0001;
    end
    unique case (r.st)
      RHB_IDLE: begin
        if (rec_start) begin
          next_r.st   = RHB_CAPTURE;
          next_r.ovr  = range_fault;
          next_r.fill = fifo_fill;
          next_r.lost = {lost_end, lost_mid, lost_begin};
          next_r.chan = rec_chan;
          next_r.trig = trigger_time_field;
          next_r.soff = rec_start_offset;
        end
      end
      RHB_CAPTURE: begin
        next_r.ovr  = status[`RHB_ST_OVR];
        next_r.fill = status[`RHB_ST_FILL_HI:`RHB_ST_FILL_LO];
        next_r.lost = status[`RHB_ST_LOST_END:`RHB_ST_LOST_BEG];
        if (rec_end) begin
          next_r.st  = RHB_SEND;
          next_r.idx = 6'd0;
          // Byte 0 first, every field little-endian
          next_r.sh  = {r.tsr, r.gp, rec_len, r.soff, r.trig, r.period,
                        r.recno, r.serial, fmt_byte, r.chan, r.uid,
                        status};
          next_r.recno = (r.recno == `RHB_REC_MAX) ? 32'h00000000
                                                   : r.recno + 32'h00000001;
        end
      end
      RHB_SEND: begin
        if (accept) begin
          next_r.sh  = {8'h00, r.sh[319:8]};
          next_r.idx = r.idx + 6'd1;
          if (r.idx == `RHB_HDR_LAST) begin
            next_r.st  = RHB_IDLE;
            next_r.idx = 6'd0;
          end
        end
      end
      default: begin
        next_r.st = RHB_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.st     <= RHB_IDLE;
      r.uid    <= `RHB_RST_USER_TAG;
      r.serial <= `RHB_RST_SERIAL;
      r.period <= `RHB_RST_PERIOD;
      r.gp     <= `RHB_RST_GP;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [5:0]  acc_cnt;
  logic [31:0] recno_q;
  logic [15:0] tsr_q;
  logic [2:0]  fill_q;
  logic        ovr_q;
  logic        in_cap;
  logic        snap_ovr;
  logic        snap_fmt;
  logic [7:0]  snap_uid;
  logic        cap_end;
  logic [5:0]  hidx;
  logic [7:0]  snap_chan;
  logic [2:0]  snap_lost;
  logic [2:0]  snap_fill;
  logic [31:0] snap_len;
  logic [31:0] snap_recno;
  logic [31:0] snap_ser;
  logic [31:0] snap_per;
  logic [63:0] snap_trig;
  logic [63:0] snap_soff;
  logic [15:0] snap_gp;
  logic [15:0] snap_tsr;
  assign hidx    = r.idx;
  assign recno_q = r.recno;
  assign tsr_q   = r.tsr;
  assign fill_q  = r.fill;
  assign ovr_q   = r.ovr;
  assign in_cap  = (r.st == RHB_CAPTURE);
  assign cap_end = in_cap && rec_end;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_cnt  <= 6'd0;
      snap_ovr <= 1'b0;
      snap_fmt <= 1'b0;
      snap_uid <= 8'h00;
      snap_chan  <= 8'h00;
      snap_lost  <= 3'h0;
      snap_fill  <= 3'h0;
      snap_len   <= 32'h00000000;
      snap_recno <= 32'h00000000;
      snap_ser   <= 32'h00000000;
      snap_per   <= 32'h00000000;
      snap_trig  <= 64'h0000000000000000;
      snap_soff  <= 64'h0000000000000000;
      snap_gp    <= 16'h0000;
      snap_tsr   <= 16'h0000;
    end else begin
      if (cap_end) begin
        snap_ovr <= status[`RHB_ST_OVR];
        snap_fmt <= r.fmt;
        snap_uid <= r.uid;
        snap_chan  <= r.chan;
        snap_lost  <= status[`RHB_ST_LOST_END:`RHB_ST_LOST_BEG];
        snap_fill  <= status[`RHB_ST_FILL_HI:`RHB_ST_FILL_LO];
        snap_len   <= rec_len;
        snap_recno <= r.recno;
        snap_ser   <= r.serial;
        snap_per   <= r.period;
        snap_trig  <= r.trig;
        snap_soff  <= r.soff;
        snap_gp    <= r.gp;
        snap_tsr   <= r.tsr;
        acc_cnt  <= 6'd0;
      end else if (accept) begin
        acc_cnt <= acc_cnt + 6'd1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_header_forty_bytes: assert property (hdr_last && hdr_ready |-> acc_cnt == 6'd39)
    else $error("header not forty bytes");
  chk_send_length: assert property (cap_end ##1 hdr_ready [*8] |=> hdr_valid)
    else $error("header ended too early");
  chk_status_range: assert property (hdr_first |-> hdr_data[7] == snap_ovr)
    else $error("range bit wrong");
  chk_lost_rec_zero: assert property (hdr_first |-> hdr_data[0] == 1'b0)
    else $error("device set lost record bit");
  chk_recno_step: assert property (cap_end && recno_q != 32'hffffffff
                                   |=> recno_q == $past(recno_q) + 32'h1)
    else $error("record count did not step");
  chk_recno_wrap: assert property (cap_end && recno_q == 32'hffffffff
                                   |=> recno_q == 32'h0)
    else $error("record count did not wrap");
  chk_fill_max: assert property (in_cap && $past(in_cap) |-> fill_q >= $past(fill_q))
    else $error("fill level dropped");
  chk_tsr_count: assert property (ts_reset_evt |=> tsr_q == $past(tsr_q) + 16'h1)
    else $error("reset count missed");
  chk_fmt_byte: assert property (hdr_valid && r.idx == 6'd3 |-> hdr_data == {7'h0, snap_fmt})
    else $error("format byte wrong");
  chk_uid_byte: assert property (hdr_valid && r.idx == 6'd1 |-> hdr_data == snap_uid)
    else $error("user tag byte wrong");
  chk_ovr_sticky: assert property (in_cap && range_fault && !rec_end |=> ovr_q)
    else $error("range fault lost");


  // ----------------------------------------
  // Field placement checks
  // ----------------------------------------
  chk_chan_byte: assert property (
    hdr_valid && hidx == 6'd2 |-> hdr_data == snap_chan)
    else $error("channel byte wrong");
  chk_lost_bits: assert property (
    hdr_first |-> hdr_data[3:1] == snap_lost)
    else $error("lost bits wrong");
  chk_fill_bits: assert property (
    hdr_first |-> hdr_data[6:4] == snap_fill)
    else $error("fill bits wrong");
  chk_serial_bytes: assert property (
    hdr_valid && hidx >= 6'd4 && hidx <= 6'd7 |-> hdr_data == snap_ser[(hidx - 6'd4) * 8 +: 8])
    else $error("serial bytes wrong");
  chk_recno_bytes: assert property (
    hdr_valid && hidx >= 6'd8 && hidx <= 6'd11 |-> hdr_data == snap_recno[(hidx - 6'd8) * 8 +: 8])
    else $error("record number bytes wrong");
  chk_period_bytes: assert property (
    hdr_valid && hidx >= 6'd12 && hidx <= 6'd15 |-> hdr_data == snap_per[(hidx - 6'd12) * 8 +: 8])
    else $error("period bytes wrong");
  chk_trig_bytes: assert property (
    hdr_valid && hidx >= 6'd16 && hidx <= 6'd23 |-> hdr_data == snap_trig[(hidx - 6'd16) * 8 +: 8])
    else $error("trigger time bytes wrong");
  chk_soff_bytes: assert property (
    hdr_valid && hidx >= 6'd24 && hidx <= 6'd31 |-> hdr_data == snap_soff[(hidx - 6'd24) * 8 +: 8])
    else $error("start offset bytes wrong");
  chk_len_bytes: assert property (
    hdr_valid && hidx >= 6'd32 && hidx <= 6'd35 |-> hdr_data == snap_len[(hidx - 6'd32) * 8 +: 8])
    else $error("length bytes wrong");
  chk_gp_bytes: assert property (
    hdr_valid && hidx >= 6'd36 && hidx <= 6'd37 |-> hdr_data == snap_gp[(hidx - 6'd36) * 8 +: 8])
    else $error("general word bytes wrong");
  chk_tsr_bytes: assert property (
    hdr_valid && hidx >= 6'd38 && hidx <= 6'd39 |-> hdr_data == snap_tsr[(hidx - 6'd38) * 8 +: 8])
    else $error("reset count bytes wrong");

  // ----------------------------------------
  // Handshake checks
  // ----------------------------------------
  chk_rdata_pulse: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside its cycle");
  chk_send_hold: assert property (
    hdr_valid && !hdr_ready |=> hdr_valid && $stable(hdr_data) && $stable(hidx))
    else $error("header byte not held");
  chk_ready_low: assert property (
    hdr_valid |-> !cap_ready)
    else $error("capture ready while sending");
  chk_idle_after: assert property (
    hdr_last && hdr_ready |=> !hdr_valid && cap_ready)
    else $error("header did not end");
  chk_start_ignored: assert property (
    hdr_valid && !hdr_last && rec_start |=> hdr_valid)
    else $error("start taken while sending");

  cov_full_header: cover property (hdr_last && hdr_ready);
  cov_fmt_wide: cover property (hdr_valid && hidx == 6'd3 && hdr_data[0]);
  cov_wrap: cover property (cap_end && recno_q == 32'hffffffff);
  cov_lost_begin: cover property (hdr_first && hdr_data[1]);
  cov_range: cover property (hdr_first && hdr_data[7]);
endmodule // rhb_header_builder
`default_nettype wire

// ===== common/rhb_map.svh
// Constants for the record header builder: offsets, field positions, resets
`ifndef RHB_MAP_SVH
`define RHB_MAP_SVH
`define RHB_HDR_BYTES    40
`define RHB_HDR_LAST     6'd39
`define RHB_ST_OVR       7
`define RHB_ST_FILL_HI   6
`define RHB_ST_FILL_LO   4
`define RHB_ST_LOST_REC  0
`define RHB_ST_LOST_BEG  1
`define RHB_ST_LOST_MID  2
`define RHB_ST_LOST_END  3
`define RHB_FMT_S16      8'h00
`define RHB_FMT_S32      8'h01
`define RHB_REG_USER_TAG 8'h00
`define RHB_REG_FORMAT   8'h04
`define RHB_REG_SERIAL   8'h08
`define RHB_REG_PERIOD   8'h0c
`define RHB_REG_GP       8'h10
`define RHB_REG_REC_CNT  8'h14
`define RHB_REG_TS_RST   8'h18
`define RHB_REG_STATUS   8'h1c
`define RHB_RST_USER_TAG 8'h00
`define RHB_RST_SERIAL   32'h00000000
`define RHB_RST_PERIOD   32'h00000000
`define RHB_RST_GP       16'h0000
`define RHB_REC_MAX      32'hffffffff
`endif

// ===== common/rhb_pkg.sv
// Types shared by the record header builder
package rhb_pkg;
  typedef enum logic [1:0] {
    RHB_IDLE    = 2'b00,
    RHB_CAPTURE = 2'b01,
    RHB_SEND    = 2'b11
  } rhb_state_t;

  typedef struct packed {
    rhb_state_t   st;
    logic [5:0]   idx;
    logic [319:0] sh;
    logic         ovr;
    logic [2:0]   fill;
    logic [2:0]   lost;
    logic [7:0]   chan;
    logic [63:0]  trig;
    logic [63:0]  soff;
    logic [31:0]  recno;
    logic [15:0]  tsr;
    logic [7:0]   uid;
    logic         fmt;
    logic [31:0]  serial;
    logic [31:0]  period;
    logic [15:0]  gp;
    logic [31:0]  rdata;
  } rhb_regs_t;
endpackage

// ===== tb/rhb_host_sink.sv
// Host-side sink: takes header bytes with random stalls
`timescale 1ns/1ps
`default_nettype none
module rhb_host_sink (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       hdr_valid,
  input  wire logic       hdr_first,
  input  wire logic       hdr_last,
  input  wire logic [7:0] hdr_data,
  output logic            hdr_ready,
  output logic            hdr_done,
  output logic            hdr_bad,
  output logic [319:0]    hdr_img
);
  int         seed = 32'h8f66;
  logic [5:0] idx;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_ready <= 1'b0;
      hdr_done  <= 1'b0;
      hdr_bad   <= 1'b0;
      hdr_img   <= '0;
      idx       <= 6'h00;
    end else begin
      hdr_ready <= ($random(seed) & 3) != 0;
      hdr_done  <= 1'b0;
      if (hdr_valid && hdr_ready) begin
        hdr_img[idx*8 +: 8] <= hdr_data;
        if (hdr_first !== (idx == 6'h00) || hdr_last !== (idx == 6'h27)) hdr_bad <= 1'b1;
        idx      <= hdr_last ? 6'h00 : idx + 6'h01;
        hdr_done <= hdr_last;
      end
    end
  end
endmodule // rhb_host_sink
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the record header builder
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic         clk, rst_n, reg_wr, reg_rd, rec_start, rec_end, range_fault, fmt, rd_d;
  logic         lost_begin, lost_mid, lost_end, ts_reset_evt, hdr_ready, cap_ready;
  logic         hdr_valid, hdr_first, hdr_last, hdr_done, hdr_bad;
  logic [7:0]   reg_addr, rec_chan, hdr_data, uid;
  logic [31:0]  reg_wdata, reg_rdata, rec_len, ser, per, recno;
  logic [63:0]  trigger_time_field, rec_start_offset;
  logic [2:0]   fifo_fill;
  logic [15:0]  gp, tsr;
  logic [319:0] hdr_img;
  logic [31:0]  rq[$];
  logic [319:0] hq[$];
  int           errors, compares, seed;

  rhb_header_builder u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rec_start(rec_start), .rec_chan(rec_chan), .trigger_time_field(trigger_time_field),
    .rec_start_offset(rec_start_offset), .rec_end(rec_end), .rec_len(rec_len),
    .range_fault(range_fault), .fifo_fill(fifo_fill), .lost_begin(lost_begin),
    .lost_mid(lost_mid), .lost_end(lost_end), .ts_reset_evt(ts_reset_evt),
    .cap_ready(cap_ready), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
    .hdr_data(hdr_data), .hdr_first(hdr_first), .hdr_last(hdr_last));
  rhb_host_sink u_sink (.clk(clk), .rst_n(rst_n), .hdr_valid(hdr_valid),
    .hdr_first(hdr_first), .hdr_last(hdr_last), .hdr_data(hdr_data),
    .hdr_ready(hdr_ready), .hdr_done(hdr_done), .hdr_bad(hdr_bad), .hdr_img(hdr_img));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [319:0] got, input logic [319:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask

  // --------------------------------
  // One record: start, faults, end
  // --------------------------------
  task automatic rec(input logic [2:0] lost, input logic flt);
    logic [63:0] t, o;
    logic [31:0] len;
    logic [7:0]  ch;
    logic [2:0]  pk;
    int          n;
    t = {$random(seed), $random(seed)};
    o = {$random(seed), $random(seed)};
    len = $random(seed);
    ch = $random(seed);
    pk = $random(seed);
    @(posedge clk);
    rec_start <= 1'b1;
    rec_chan <= ch;
    trigger_time_field <= t;
    rec_start_offset <= o;
    fifo_fill <= pk >> 1;
    @(posedge clk);
    rec_start <= 1'b0;
    rec_chan <= ~ch;
    trigger_time_field <= ~t;
    range_fault <= flt;
    fifo_fill <= pk;
    {lost_end, lost_mid, lost_begin} <= lost;
    ts_reset_evt <= 1'b1;
    @(posedge clk);
    rec_start <= 1'b1;
    range_fault <= 1'b0;
    fifo_fill <= 3'h0;
    {lost_end, lost_mid, lost_begin} <= 3'h0;
    ts_reset_evt <= 1'b0;
    @(posedge clk);
    rec_start <= 1'b0;
    rec_end <= 1'b1;
    rec_len <= len;
    tsr = tsr + 16'h1;
    @(posedge clk);
    rec_end <= 1'b0;
    hq.push_back({tsr, gp, len, o, t,
                  per, recno, ser,
                  7'h0, fmt, ch, uid,
                  flt, pk, lost, 1'b0});
    recno = recno + 32'h1;
    n = 0;
    @(posedge clk);
    #1;
    while (!cap_ready && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      errors++;
      $display("FAIL %0t header stuck", $time);
    end
  endtask

  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(320'(reg_rdata), 320'(rq.pop_front()));
    if (hdr_done) chk(hdr_img, hq.pop_front());
  end

  initial begin
    {reg_wr, reg_rd, rec_start, rec_end, range_fault, rd_d} = '0;
    {lost_begin, lost_mid, lost_end, ts_reset_evt, fmt} = '0;
    {reg_addr, reg_wdata, rec_chan, rec_len, fifo_fill} = '0;
    {trigger_time_field, rec_start_offset, recno, tsr} = '0;
    seed = 32'h8f66;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(8'(a * 4), 32'h0);
    uid = $random(seed);
    ser = $random(seed);
    gp = $random(seed);
    per = 32'hfffffff0;
    wr(8'h00, {24'h0, uid});
    wr(8'h08, ser);
    wr(8'h0c, per);
    wr(8'h10, {16'h0, gp});
    wr(8'h14, 32'h1234);
    wr(8'hfc, 32'h5a5a);
    rd(8'h00, {24'h0, uid});
    rd(8'h08, ser);
    rd(8'h0c, per);
    rd(8'h10, {16'h0, gp});
    rd(8'h14, 32'h0);
    rd(8'hfc, 32'h0);
    for (int i = 0; i < 8; i++) begin
      fmt = i[0];
      wr(8'h04, {31'h0, fmt});
      rec(i[2:0], i[1]);
    end
    rd(8'h14, recno);
    rd(8'h18, {16'h0, tsr});
    repeat (5) @(posedge clk);
    chk(320'(hq.size()), 320'h0);
    chk(320'(hdr_bad), 320'h0);
    end_sim;
  end

  initial begin
    #100000;
    errors++;
    $display("FAIL %0t timeout", $time);
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
